// >>> fcm_host.sv
// Host-side controller driving a parallel NOR flash through its pins
//
// Notes on behaviour
// - After reset release, wait the reset-to-read delay before reading.
// - A program or erase cut by our reset while being polled is issued again, unless another reset request cycle comes before the reset wait ends.
// - Program is sent only as the full three-cycle unlock plus command.
// - Erase is sent only as the full six-cycle unlock sequence.
// - Upper eight data bits are driven low in command cycles.
// - Query mode entered by three cycles ending with 98H at 555H.
// - Query mode holds until the exit command, another entry command or a hardware reset.
// - User security half programmed by its own command, polled by toggle bit.
// - Security query entered by three cycles ending 88H at 555H.
`timescale 1ns/10ps
module fcm_host (
  input  wire logic                      mclk,
  input  wire logic                      rstn,
  input  wire fcm_pkg::fcm_req_s         req,
  input  wire logic                      req_valid,
  input  wire logic                      hw_reset_req,
  input  wire logic                      boot_protect,
  output logic                           req_ready,
  output logic                           rsp_valid,
  output logic [fcm_pkg::DATA_W-1:0]     rsp_data,
  output fcm_pkg::fcm_mode_e             mode,
  output logic                           reissued,
  output fcm_pkg::fcm_bus_s              flash_bus,
  output logic                           flash_rst_n,
  output logic                           flash_wp_n,
  input  wire logic [fcm_pkg::DATA_W-1:0] flash_dq_i
);

  typedef enum logic [2:0] {
    S_IDLE, S_RST_LOW, S_RST_WAIT, S_SEQ, S_POLL, S_RSP
  } fcm_state_e;

  fcm_state_e                    st_q;
  fcm_pkg::fcm_req_s             cur_q;
  logic [2:0]                    step_q;
  logic [fcm_pkg::CNT_W-1:0]     cnt_q;
  logic                          issued_q;
  logic                          altering_q;
  logic                          poll_first_q;
  logic                          tog_q;
  logic                          bc_start;
  logic                          bc_write;
  logic                          bc_done;
  logic [fcm_pkg::DATA_W-1:0]    bc_rdata;
  logic [fcm_pkg::ADDR_W-1:0]    bc_addr;
  logic [fcm_pkg::DATA_W-1:0]    bc_wdata;
  logic                          bc_abort;

  // ==========================================================
  // Command sequence tables
  // ==========================================================
  function automatic logic [2:0] seq_len(input fcm_pkg::fcm_op_e op);
    case (op)
      fcm_pkg::OP_READ:                                 seq_len = 3'd0;
      fcm_pkg::OP_PROGRAM, fcm_pkg::OP_SEC_PROGRAM,
      fcm_pkg::OP_SEC_LOCK:                             seq_len = 3'd4;
      fcm_pkg::OP_SEC_ERASE, fcm_pkg::OP_BLK_ERASE,
      fcm_pkg::OP_CHIP_ERASE:                           seq_len = 3'd6;
      default:                                          seq_len = 3'd3;
    endcase
  endfunction

  function automatic logic [7:0] third_cmd(input fcm_pkg::fcm_op_e op);
    case (op)
      fcm_pkg::OP_PROGRAM:     third_cmd = fcm_pkg::CMD_PROGRAM;
      fcm_pkg::OP_SEC_PROGRAM: third_cmd = fcm_pkg::CMD_SEC_PROG;
      fcm_pkg::OP_SEC_LOCK:    third_cmd = fcm_pkg::CMD_SEC_LOCK;
      fcm_pkg::OP_ID_ENTRY:    third_cmd = fcm_pkg::CMD_ID_ENTRY;
      fcm_pkg::OP_QUERY_ENTRY: third_cmd = fcm_pkg::CMD_QUERY;
      fcm_pkg::OP_SEC_ENTRY:   third_cmd = fcm_pkg::CMD_SEC;
      fcm_pkg::OP_EXIT:        third_cmd = fcm_pkg::CMD_EXIT;
      default:                 third_cmd = fcm_pkg::CMD_ERASE;
    endcase
  endfunction

  function automatic logic [7:0] sixth_cmd(input fcm_pkg::fcm_op_e op);
    case (op)
      fcm_pkg::OP_SEC_ERASE: sixth_cmd = fcm_pkg::CMD_SECTOR;
      fcm_pkg::OP_BLK_ERASE: sixth_cmd = fcm_pkg::CMD_BLOCK;
      default:               sixth_cmd = fcm_pkg::CMD_CHIP;
    endcase
  endfunction

  // Command address: A10..A0 only, upper bits held low
  function automatic logic [fcm_pkg::ADDR_W-1:0] cmd_addr(input logic [10:0] a);
    cmd_addr = {{(fcm_pkg::ADDR_W - $bits(a)){1'b0}}, a};
  endfunction

  // Command data: upper byte driven low, never left floating
  function automatic logic [fcm_pkg::DATA_W-1:0] cmd_data(input logic [7:0] d);
    cmd_data = {8'h00, d};
  endfunction

  // ==========================================================
  // Address and data for the current step
  // ==========================================================
  always_comb begin
    bc_addr  = cur_q.addr;
    bc_wdata = cur_q.data;
    bc_write = 1'b0;
    if (st_q == S_SEQ && step_q < seq_len(cur_q.op)) begin
      bc_write = 1'b1;
      case (step_q)
        3'd0, 3'd3: begin
          if (step_q == 3'd3 && seq_len(cur_q.op) == 3'd4) begin
            bc_addr  = cur_q.addr;
            bc_wdata = (cur_q.op == fcm_pkg::OP_SEC_LOCK) ? fcm_pkg::SEC_LOCK_DAT
                                                           : cur_q.data;
          end else begin
            bc_addr  = cmd_addr(fcm_pkg::ADR_UNLOCK1);
            bc_wdata = cmd_data(fcm_pkg::DAT_UNLOCK1);
          end
        end
        3'd1, 3'd4: begin
          bc_addr  = cmd_addr(fcm_pkg::ADR_UNLOCK2);
          bc_wdata = cmd_data(fcm_pkg::DAT_UNLOCK2);
        end
        3'd2: begin
          bc_addr  = cmd_addr(fcm_pkg::ADR_UNLOCK1);
          bc_wdata = cmd_data(third_cmd(cur_q.op));
        end
        default: begin
          bc_wdata = cmd_data(sixth_cmd(cur_q.op));
          if (cur_q.op == fcm_pkg::OP_SEC_ERASE) begin
            bc_addr = {cur_q.addr[fcm_pkg::ADDR_W-1:fcm_pkg::SECTOR_LSB],
                       {fcm_pkg::SECTOR_LSB{1'b0}}};
          end else if (cur_q.op == fcm_pkg::OP_BLK_ERASE) begin
            bc_addr = {cur_q.addr[fcm_pkg::ADDR_W-1:fcm_pkg::BLOCK_LSB],
                       {fcm_pkg::BLOCK_LSB{1'b0}}};
          end else begin
            bc_addr = cmd_addr(fcm_pkg::ADR_UNLOCK1);
          end
        end
      endcase
    end
  end

  assign bc_abort = hw_reset_req;

  // ==========================================================
  // Main sequencer
  // ==========================================================
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st_q         <= S_IDLE;
      cur_q        <= '0;
      step_q       <= '0;
      cnt_q        <= '0;
      issued_q     <= 1'b0;
      altering_q   <= 1'b0;
      poll_first_q <= 1'b0;
      tog_q        <= 1'b0;
      bc_start     <= 1'b0;
      req_ready    <= 1'b0;
      rsp_valid    <= 1'b0;
      rsp_data     <= '0;
      reissued     <= 1'b0;
      flash_rst_n  <= 1'b1;
    end else begin
      bc_start  <= 1'b0;
      rsp_valid <= 1'b0;
      reissued  <= 1'b0;
      if (hw_reset_req) begin
        // Remember an altering operation the reset is about to cut off
        altering_q  <= (st_q == S_SEQ || st_q == S_POLL) && issued_q;
        req_ready   <= 1'b0;
        flash_rst_n <= 1'b0;
        cnt_q       <= fcm_pkg::CNT_W'(fcm_pkg::RESET_PULSE_CYC);
        st_q        <= S_RST_LOW;
      end else begin
        case (st_q)
          S_IDLE: begin
            req_ready <= 1'b1;
            if (req_valid && req_ready) begin
              req_ready <= 1'b0;
              cur_q     <= req;
              step_q    <= '0;
              issued_q  <= 1'b0;
              bc_start  <= 1'b1;
              st_q      <= S_SEQ;
            end
          end
          S_RST_LOW: begin
            if (cnt_q > 1) begin
              cnt_q <= cnt_q - 1'b1;
            end else begin
              flash_rst_n <= 1'b1;
              cnt_q       <= fcm_pkg::CNT_W'(fcm_pkg::RESET_TO_READ_CYC);
              st_q        <= S_RST_WAIT;
            end
          end
          S_RST_WAIT: begin
            if (cnt_q > 1) begin
              cnt_q <= cnt_q - 1'b1;
            end else if (altering_q) begin
              altering_q <= 1'b0;
              reissued   <= 1'b1;
              step_q     <= '0;
              issued_q   <= 1'b0;
              bc_start   <= 1'b1;
              st_q       <= S_SEQ;
            end else begin
              st_q <= S_IDLE;
            end
          end
          S_SEQ: begin
            if (bc_done) begin
              if (step_q + 3'd1 < seq_len(cur_q.op)) begin
                step_q   <= step_q + 3'd1;
                bc_start <= 1'b1;
              end else if (seq_len(cur_q.op) == 3'd0) begin
                rsp_data <= bc_rdata;
                st_q     <= S_RSP;
              end else if (seq_len(cur_q.op) == 3'd3) begin
                st_q <= S_RSP;
              end else begin
                // Toggle polling only: complement polling is wrong for the
                // security space, and toggling works for every operation
                issued_q     <= 1'b1;
                step_q       <= seq_len(cur_q.op);
                poll_first_q <= 1'b1;
                bc_start     <= 1'b1;
                st_q         <= S_POLL;
              end
            end
          end
          S_POLL: begin
            if (bc_done) begin
              tog_q        <= bc_rdata[fcm_pkg::TOGGLE_BIT];
              poll_first_q <= 1'b0;
              if (!poll_first_q && bc_rdata[fcm_pkg::TOGGLE_BIT] == tog_q) begin
                rsp_data <= bc_rdata;
                issued_q <= 1'b0;
                st_q     <= S_RSP;
              end else begin
                bc_start <= 1'b1;
              end
            end
          end
          S_RSP: begin
            rsp_valid <= 1'b1;
            st_q      <= S_IDLE;
          end
          default: st_q <= S_IDLE;
        endcase
      end
    end
  end

  // ==========================================================
  // Mode tracking and write-protect pin
  // ==========================================================
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      mode <= fcm_pkg::MODE_ARRAY;
    end else if (hw_reset_req) begin
      mode <= fcm_pkg::MODE_ARRAY;
    end else if (st_q == S_SEQ && bc_done && step_q == 3'd2 &&
                 seq_len(cur_q.op) == 3'd3) begin
      case (cur_q.op)
        fcm_pkg::OP_ID_ENTRY:    mode <= fcm_pkg::MODE_ID;
        fcm_pkg::OP_QUERY_ENTRY: mode <= fcm_pkg::MODE_QUERY;
        fcm_pkg::OP_SEC_ENTRY:   mode <= fcm_pkg::MODE_SEC;
        default:                 mode <= fcm_pkg::MODE_ARRAY;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      flash_wp_n <= 1'b1;
    end else if (st_q == S_IDLE) begin
      // Held steady through each sequence
      flash_wp_n <= ~boot_protect;
    end
  end

  fcm_bus_cycle u_cycle (
    .mclk     (mclk),
    .rstn     (rstn),
    .abort    (bc_abort),
    .start    (bc_start),
    .is_write (bc_write),
    .addr     (bc_addr),
    .wdata    (bc_wdata),
    .dq_i     (flash_dq_i),
    .bus      (flash_bus),
    .done     (bc_done),
    .rdata    (bc_rdata)
  );

endmodule

// >>> fcm_pkg.sv
// Shared constants and types for the flash command and mode controller
package fcm_pkg;

  // ==========================================================
  // Clock and timing
  // ==========================================================
  localparam int CLK_NS              = 20;
  // Plain defaults: no figure is fixed for these times
  localparam int RESET_PULSE_MIN_NS  = 500;
  localparam int RESET_TO_READ_NS    = 1000;
  localparam int READ_CYCLE_TIME_NS  = 70;
  localparam int WE_SETUP_NS         = 20;
  localparam int WE_LOW_NS           = 40;
  localparam int WE_HOLD_NS          = 30;
  // Least times round up
  localparam int RESET_PULSE_CYC     = (RESET_PULSE_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int RESET_TO_READ_CYC   = (RESET_TO_READ_NS + CLK_NS - 1) / CLK_NS;
  localparam int READ_CYCLE_CYC      = (READ_CYCLE_TIME_NS + CLK_NS - 1) / CLK_NS;
  localparam int WE_SETUP_CYC        = (WE_SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int WE_LOW_CYC          = (WE_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int WE_HOLD_CYC         = (WE_HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int SYNC_CYC            = 2;
  localparam int CNT_W               = 16;

  // ==========================================================
  // Bus geometry
  // ==========================================================
  localparam int ADDR_W              = 22;
  localparam int DATA_W              = 16;
  localparam int TOGGLE_BIT          = 6;
  localparam int SECTOR_LSB          = 11;
  localparam int BLOCK_LSB           = 15;

  // ==========================================================
  // Command cycle codes
  // ==========================================================
  localparam logic [10:0] ADR_UNLOCK1  = 11'h555;
  localparam logic [10:0] ADR_UNLOCK2  = 11'h2AA;
  localparam logic [7:0]  DAT_UNLOCK1  = 8'hAA;
  localparam logic [7:0]  DAT_UNLOCK2  = 8'h55;
  localparam logic [7:0]  CMD_PROGRAM  = 8'hA0;
  localparam logic [7:0]  CMD_ERASE    = 8'h80;
  localparam logic [7:0]  CMD_SECTOR   = 8'h50;
  localparam logic [7:0]  CMD_BLOCK    = 8'h30;
  localparam logic [7:0]  CMD_CHIP     = 8'h10;
  localparam logic [7:0]  CMD_ID_ENTRY = 8'h90;
  localparam logic [7:0]  CMD_QUERY    = 8'h98;
  localparam logic [7:0]  CMD_SEC      = 8'h88;
  localparam logic [7:0]  CMD_SEC_PROG = 8'hA5;
  localparam logic [7:0]  CMD_SEC_LOCK = 8'h85;
  localparam logic [7:0]  CMD_EXIT     = 8'hF0;
  localparam logic [15:0] SEC_LOCK_DAT = 16'h0000;

  // ==========================================================
  // Types
  // ==========================================================
  typedef enum logic [3:0] {
    OP_READ, OP_PROGRAM, OP_SEC_ERASE, OP_BLK_ERASE, OP_CHIP_ERASE,
    OP_ID_ENTRY, OP_QUERY_ENTRY, OP_SEC_ENTRY, OP_EXIT,
    OP_SEC_PROGRAM, OP_SEC_LOCK
  } fcm_op_e;

  typedef enum logic [1:0] {
    MODE_ARRAY, MODE_ID, MODE_QUERY, MODE_SEC
  } fcm_mode_e;

  typedef struct packed {
    fcm_op_e             op;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   data;
  } fcm_req_s;

  typedef struct packed {
    logic                ce_n;
    logic                oe_n;
    logic                we_n;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   dq_o;
    logic                dq_oe;
  } fcm_bus_s;

endpackage

// >>> fcm_bus_cycle.sv
// One asynchronous flash bus cycle, write or read, on the flash pins
`timescale 1ns/10ps
module fcm_bus_cycle (
  input  wire logic                      mclk,
  input  wire logic                      rstn,
  input  wire logic                      abort,
  input  wire logic                      start,
  input  wire logic                      is_write,
  input  wire logic [fcm_pkg::ADDR_W-1:0] addr,
  input  wire logic [fcm_pkg::DATA_W-1:0] wdata,
  input  wire logic [fcm_pkg::DATA_W-1:0] dq_i,
  output fcm_pkg::fcm_bus_s              bus,
  output logic                           done,
  output logic [fcm_pkg::DATA_W-1:0]     rdata
);

  typedef enum logic [1:0] {BC_IDLE, BC_SETUP, BC_STROBE, BC_HOLD} fcm_bc_e;

  fcm_bc_e                          st_q;
  logic                             wr_q;
  logic [fcm_pkg::CNT_W-1:0]        cnt_q;
  logic [fcm_pkg::DATA_W-1:0]       dq_s1_q;
  logic [fcm_pkg::DATA_W-1:0]       dq_s2_q;

  // ==========================================================
  // Data pin synchroniser
  // ==========================================================
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      dq_s1_q <= '0;
      dq_s2_q <= '0;
    end else begin
      dq_s1_q <= dq_i;
      dq_s2_q <= dq_s1_q;
    end
  end

  // ==========================================================
  // Cycle sequencer
  // ==========================================================
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st_q      <= BC_IDLE;
      wr_q      <= 1'b0;
      cnt_q     <= '0;
      done      <= 1'b0;
      rdata     <= '0;
      bus.ce_n  <= 1'b1;
      bus.oe_n  <= 1'b1;
      bus.we_n  <= 1'b1;
      bus.addr  <= '0;
      bus.dq_o  <= '0;
      bus.dq_oe <= 1'b0;
    end else begin
      done <= 1'b0;
      if (abort) begin
        st_q      <= BC_IDLE;
        bus.ce_n  <= 1'b1;
        bus.oe_n  <= 1'b1;
        bus.we_n  <= 1'b1;
        bus.dq_oe <= 1'b0;
      end else begin
        case (st_q)
          BC_IDLE: begin
            if (start) begin
              wr_q      <= is_write;
              bus.addr  <= addr;
              bus.dq_o  <= wdata;
              bus.ce_n  <= 1'b0;
              // Drive data only while the gate is high, never against the device
              bus.dq_oe <= is_write;
              bus.oe_n  <= is_write;
              cnt_q     <= is_write ? CNT_W_CAST(fcm_pkg::WE_SETUP_CYC)
                                    : CNT_W_CAST(fcm_pkg::READ_CYCLE_CYC
                                                 + fcm_pkg::SYNC_CYC);
              st_q      <= BC_SETUP;
            end
          end
          BC_SETUP: begin
            if (cnt_q > 1) begin
              cnt_q <= cnt_q - 1'b1;
            end else if (wr_q) begin
              bus.we_n <= 1'b0;
              cnt_q    <= CNT_W_CAST(fcm_pkg::WE_LOW_CYC);
              st_q     <= BC_STROBE;
            end else begin
              rdata    <= dq_s2_q;
              bus.oe_n <= 1'b1;
              cnt_q    <= CNT_W_CAST(fcm_pkg::WE_HOLD_CYC);
              st_q     <= BC_HOLD;
            end
          end
          BC_STROBE: begin
            if (cnt_q > 1) begin
              cnt_q <= cnt_q - 1'b1;
            end else begin
              // Write strobe rises before chip select, so it marks the cycle
              bus.we_n <= 1'b1;
              cnt_q    <= CNT_W_CAST(fcm_pkg::WE_HOLD_CYC);
              st_q     <= BC_HOLD;
            end
          end
          BC_HOLD: begin
            if (cnt_q > 1) begin
              cnt_q <= cnt_q - 1'b1;
            end else begin
              bus.ce_n  <= 1'b1;
              bus.dq_oe <= 1'b0;
              done      <= 1'b1;
              st_q      <= BC_IDLE;
            end
          end
          default: st_q <= BC_IDLE;
        endcase
      end
    end
  end

  function automatic logic [fcm_pkg::CNT_W-1:0] CNT_W_CAST(input int v);
    CNT_W_CAST = v[fcm_pkg::CNT_W-1:0];
  endfunction

endmodule

// >>> fcm_host_sva.sv
// Pin timing checks for the host flash controller
`timescale 1ns/10ps
module fcm_host_sva (
  input wire logic              mclk,
  input wire logic              rstn,
  input wire fcm_pkg::fcm_bus_s flash_bus,
  input wire logic              flash_rst_n
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  // ==========================================================
  // Strobes
  // ==========================================================
  AST_NO_WE_OE: assert property (!(!flash_bus.we_n && !flash_bus.oe_n))
    else $error("write strobe and output gate low together");
  AST_WE_IN_CE: assert property (!flash_bus.we_n |-> !flash_bus.ce_n)
    else $error("write strobe low without chip select");
  AST_WE_LOW: assert property ($fell(flash_bus.we_n) |-> !flash_bus.we_n [*2] ##1 flash_bus.we_n)
    else $error("write strobe width wrong");
  AST_WR_STABLE: assert property (!flash_bus.we_n |-> $stable(flash_bus.addr)
    && $stable(flash_bus.dq_o) && flash_bus.dq_oe)
    else $error("address or data moved during write strobe");
  AST_NO_DRIVE_RD: assert property (!flash_bus.oe_n |-> !flash_bus.dq_oe)
    else $error("host drives data while device outputs enabled");
  // ==========================================================
  // Flash reset pin
  // ==========================================================
  AST_RST_PULSE: assert property ($fell(flash_rst_n) |-> ##24 !flash_rst_n)
    else $error("flash reset pulse too short");
  AST_RST_QUIET: assert property (!flash_rst_n |-> flash_bus.ce_n)
    else $error("bus cycle while flash in reset");
  AST_READ_DELAY: assert property ($rose(flash_rst_n) |-> flash_bus.ce_n [*8] ##40 flash_bus.ce_n)
    else $error("access too soon after flash reset");
endmodule

bind fcm_host fcm_host_sva fcm_host_sva_inst (
  .mclk(mclk), .rstn(rstn), .flash_bus(flash_bus), .flash_rst_n(flash_rst_n));

// >>> fcm_flash_model.sv
// Behavioural parallel NOR flash device facing the host controller
`timescale 1ns/10ps
module fcm_flash_model #(
  parameter logic [15:0] MAKER = 16'h0011, // Arbitrary identity values
  parameter logic [15:0] DEVC  = 16'h0022
) (
  input  wire fcm_pkg::fcm_bus_s bus,
  input  wire logic              rst_n,
  input  wire logic              wp_n,
  output logic [15:0]            dq
);
  logic [15:0]        mem [64];
  logic [15:0]        usr [8];
  logic [15:0]        rd;
  logic [7:0]         cmd;
  logic [2:0]         step;
  logic               locked;
  int                 rd_n;
  int                 busy_till;
  fcm_pkg::fcm_mode_e md;
  wire [10:0] a    = bus.addr[10:0];
  wire [7:0]  d    = bus.dq_o[7:0];
  wire        busy = rd_n < busy_till;
  wire        boot = !wp_n && bus.addr[21:15] == 7'h00;
  wire        hit  = d == 8'h10 || d == 8'h50 && bus.addr[21:11] == 11'h000
                     || d == 8'h30 && bus.addr[21:15] == 7'h00;
  initial begin
    foreach (mem[i]) mem[i] = '1;
    foreach (usr[i]) usr[i] = '1;
    {locked, step, rd_n, busy_till} = '0;
    md = fcm_pkg::MODE_ARRAY;
  end
  // Each completed read advances the status toggle
  always @(posedge (bus.oe_n | bus.ce_n)) rd_n <= rd_n + 1;
  always @(posedge (bus.we_n | bus.ce_n) or negedge rst_n) begin
    if (!rst_n) begin
      step <= 3'h0;
      busy_till <= rd_n;
      md <= fcm_pkg::MODE_ARRAY;
    end else if (!busy && bus.oe_n) begin
      step <= 3'h0;
      case (step)
        0, 3: if (a == 11'h555 && d == 8'hAA) step <= step + 3'h1;
        1, 4: if (a == 11'h2AA && d == 8'h55) step <= step + 3'h1;
        2: begin
          cmd <= d;
          if (a == 11'h555) case (d)
            8'hA0, 8'hA5, 8'h85: step <= 3'h6;
            8'h80: step <= 3'h3;
            8'h90: md <= fcm_pkg::MODE_ID;
            8'h98: md <= fcm_pkg::MODE_QUERY;
            8'h88: md <= fcm_pkg::MODE_SEC;
            8'hF0: md <= fcm_pkg::MODE_ARRAY;
            default: ;
          endcase
        end
        5: begin
          busy_till <= rd_n + 3;
          // Security words live apart and are never cleared
          if (hit && !boot) foreach (mem[i]) mem[i] <= '1;
        end
        6: begin
          busy_till <= rd_n + 3;
          if (cmd == 8'hA0 && !boot) mem[bus.addr[5:0]] <= mem[bus.addr[5:0]] & bus.dq_o;
          if (cmd == 8'hA5 && !locked && bus.addr[4])
            usr[bus.addr[2:0]] <= usr[bus.addr[2:0]] & bus.dq_o;
          if (cmd == 8'h85) locked <= 1'b1;
        end
        default: ;
      endcase
    end
  end
  always_comb begin
    case (md)
      fcm_pkg::MODE_ID:    rd = a[0] ? DEVC : MAKER;
      fcm_pkg::MODE_QUERY: rd = 16'h0051;
      fcm_pkg::MODE_SEC:   rd = a[4] ? usr[a[2:0]] : 16'hC0DE ^ a[2:0];
      default:             rd = mem[bus.addr[5:0]];
    endcase
    if (busy) rd = {9'h000, rd_n[0], 6'h00};
  end
  // Released bus shows inverted data, never a stale match
  assign dq = (bus.ce_n | bus.oe_n) ? ~rd : rd;
endmodule

// >>> test_fcm_host.sv
// Self-checking bench for the host flash controller and device model
`timescale 1ns/10ps
module test_fcm_host;
  localparam logic [15:0] MK = 16'h00A5; // Arbitrary
  localparam logic [15:0] DV = 16'h5A01; // Arbitrary
  localparam fcm_pkg::fcm_mode_e AR = fcm_pkg::MODE_ARRAY;
  localparam fcm_pkg::fcm_mode_e ID = fcm_pkg::MODE_ID;
  localparam fcm_pkg::fcm_mode_e QU = fcm_pkg::MODE_QUERY;
  localparam fcm_pkg::fcm_mode_e SE = fcm_pkg::MODE_SEC;
  typedef struct {
    fcm_pkg::fcm_op_e op; logic [21:0] a; logic [15:0] d, x; fcm_pkg::fcm_mode_e m;
  } fcm_row_s;
  fcm_row_s rows [27] = '{
    '{fcm_pkg::OP_PROGRAM, 22'h5, 16'h1234, 16'h0, AR}, '{fcm_pkg::OP_READ, 22'h5, 16'h0, 16'h1234, AR},
    '{fcm_pkg::OP_ID_ENTRY, 22'h0, 16'h0, 16'h0, ID}, '{fcm_pkg::OP_READ, 22'h0, 16'h0, MK, ID},
    '{fcm_pkg::OP_READ, 22'h1, 16'h0, DV, ID}, '{fcm_pkg::OP_EXIT, 22'h0, 16'h0, 16'h0, AR},
    '{fcm_pkg::OP_QUERY_ENTRY, 22'h0, 16'h0, 16'h0, QU}, '{fcm_pkg::OP_READ, 22'h0, 16'h0, 16'h0051, QU},
    '{fcm_pkg::OP_SEC_ENTRY, 22'h0, 16'h0, 16'h0, SE}, '{fcm_pkg::OP_SEC_PROGRAM, 22'h10, 16'hAB00, 16'h0, SE},
    '{fcm_pkg::OP_SEC_LOCK, 22'h10, 16'h0, 16'h0, SE}, '{fcm_pkg::OP_SEC_PROGRAM, 22'h11, 16'h0, 16'h0, SE},
    '{fcm_pkg::OP_READ, 22'h10, 16'h0, 16'hAB00, SE}, '{fcm_pkg::OP_READ, 22'h11, 16'h0, 16'hFFFF, SE},
    '{fcm_pkg::OP_READ, 22'h3, 16'h0, 16'hC0DD, SE}, '{fcm_pkg::OP_EXIT, 22'h0, 16'h0, 16'h0, AR},
    '{fcm_pkg::OP_SEC_ERASE, 22'h0, 16'h0, 16'h0, AR}, '{fcm_pkg::OP_READ, 22'h5, 16'h0, 16'hFFFF, AR},
    '{fcm_pkg::OP_READ, 22'h9, 16'h0, 16'hFFFF, AR},
    '{fcm_pkg::OP_PROGRAM, 22'h3, 16'h00F0, 16'h0, AR},
    '{fcm_pkg::OP_BLK_ERASE, 22'h8000, 16'h0, 16'h0, AR},
    '{fcm_pkg::OP_READ, 22'h3, 16'h0, 16'h00F0, AR},
    '{fcm_pkg::OP_BLK_ERASE, 22'h7FFF, 16'h0, 16'h0, AR},
    '{fcm_pkg::OP_READ, 22'h3, 16'h0, 16'hFFFF, AR},
    '{fcm_pkg::OP_PROGRAM, 22'h4, 16'h0F0F, 16'h0, AR},
    '{fcm_pkg::OP_CHIP_ERASE, 22'h0, 16'h0, 16'h0, AR},
    '{fcm_pkg::OP_READ, 22'h4, 16'h0, 16'hFFFF, AR}};
  logic mclk = 0, rstn = 0, req_valid = 0, hw_reset_req = 0, boot_protect = 0;
  logic req_ready, rsp_valid, reissued, flash_rst_n, flash_wp_n;
  logic [15:0]        rsp_data, dq;
  fcm_pkg::fcm_req_s  req = '0;
  fcm_pkg::fcm_mode_e mode;
  fcm_pkg::fcm_bus_s  flash_bus;
  int miscompares = 0, comparisons = 0, cyc = 0, nre = 0;
  fcm_host fcm_host_inst (.mclk(mclk), .rstn(rstn), .req(req), .req_valid(req_valid),
    .hw_reset_req(hw_reset_req), .boot_protect(boot_protect), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .mode(mode), .reissued(reissued),
    .flash_bus(flash_bus), .flash_rst_n(flash_rst_n), .flash_wp_n(flash_wp_n), .flash_dq_i(dq));
  fcm_flash_model #(.MAKER(MK), .DEVC(DV)) fcm_flash_model_inst (.bus(flash_bus),
    .rst_n(flash_rst_n), .wp_n(flash_wp_n), .dq(dq));
  initial forever #10 mclk = ~mclk;
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic do_req(input fcm_pkg::fcm_op_e op, input logic [21:0] a, input logic [15:0] d);
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 500) begin
      @(negedge mclk);
      n++;
    end
    if (n == 500) check("ready", 16'h0001, 16'h0000);
    req = '{op, a, d};
    req_valid = 1;
    @(negedge mclk);
    req_valid = 0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 2000) begin
      @(negedge mclk);
      n++;
    end
    if (n == 2000) check("response", 16'h0001, 16'h0000);
    @(negedge mclk);
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (reissued === 1'b1) nre++;
    if (cyc == 20000) begin
      miscompares++;
      summarize();
    end
  end
  initial begin
    repeat (20) @(negedge mclk);
    check("ce_n", 16'h0001, flash_bus.ce_n);
    check("rst_pin", 16'h0001, flash_rst_n);
    rstn = 1;
    foreach (rows[i]) begin
      do_req(rows[i].op, rows[i].a, rows[i].d);
      if (rows[i].op == fcm_pkg::OP_READ) check("rdata", rows[i].x, rsp_data);
      check("mode", 16'(rows[i].m), 16'(mode));
      $display("row %0d done", i);
    end
    boot_protect = 1;
    do_req(fcm_pkg::OP_PROGRAM, 22'h6, 16'h0000);
    boot_protect = 0;
    do_req(fcm_pkg::OP_READ, 22'h6, 16'h0000);
    check("boot", 16'hFFFF, rsp_data);
    $display("boot block test done");
    fork
      do_req(fcm_pkg::OP_PROGRAM, 22'h9, 16'h00FF);
      begin
        repeat (40) @(negedge mclk);
        hw_reset_req = 1;
        @(negedge mclk);
        hw_reset_req = 0;
      end
    join
    check("reissue", 16'h0001, 16'(nre));
    do_req(fcm_pkg::OP_READ, 22'h9, 16'h0000);
    check("rdata", 16'h00FF, rsp_data);
    $display("reset test done");
    summarize();
  end
endmodule
